// ===== test/tb_top.sv
// Self-checking bench for the unknown-frame control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans, lkp_class, ingress_period_sel;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic lkp_valid, lkp_done, lkp_special, lkp_drop, egr_valid, egr_done, egr_discard;
	logic tag_valid, tag_done, tag_insert, egr_queue_mode, ingress_period_tick;
	logic [4:0] lkp_port_mask, port_ctrl0_tag;
	logic [47:0] egr_sa, own_mac;
	logic [2:0] tag_src_port, tag_egr_port;
	logic [24:0] port_ctrl8_tag;
	logic [7:0] mreg [4];
	logic [7:0] wm [4] = '{8'h3F, 8'h3F, 8'h7F, 8'h3C};
	logic [4:0] maps [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0F, 5'h1F};
	int n_mismatch = 0;
	int checks_done = 0;
	int i, j, n;
	ufc_unknown_fwd_ctrl #(.CNT_W(9), .P16_CYC(16), .P64_CYC(64), .P256_CYC(256))
	ufc_unknown_fwd_ctrl_i (
		.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout, .hrdata, .hresp, .lkp_valid, .lkp_class, .lkp_done, .lkp_special,
		.lkp_drop, .lkp_port_mask, .egr_valid, .egr_sa, .own_mac, .egr_done, .egr_discard,
		.tag_valid, .tag_src_port, .tag_egr_port, .port_ctrl8_tag, .port_ctrl0_tag,
		.tag_done, .tag_insert, .egr_queue_mode, .ingress_period_sel, .ingress_period_tick
	);
	// Single slave: its ready is the bus ready
	assign hready = hreadyout;
	// Clock at 100 MHz
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// One single word transfer; read data is compared with v
	task automatic ahb(input int k, input logic w, input logic [31:0] v);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= 32'h210 + 32'(k) * 4;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		chk({31'h0, hresp}, 32'h0);
		if (!w)
			chk(hrdata, v);
	endtask
	// Register write with noise in the unused upper bits; model keeps writable bits
	task automatic wr(input int k, input logic [7:0] v);
		ahb(k, 1'b1, {24'($urandom), v});
		if (k < 4)
			mreg[k] = (mreg[k] & ~wm[k]) | (v & wm[k]);
	endtask
	// Read all four registers and one unmapped word
	task automatic rd_all;
		for (int k = 0; k < 5; k++)
			ahb(k, 1'b0, k < 4 ? {24'h0, mreg[k]} : 32'h0);
	endtask
	// Reset, then read back the reset values
	task automatic reset_check(input int cyc);
		rst <= 1'b1;
		repeat (cyc) @(posedge core_clk);
		chk({hreadyout, hresp, lkp_done, egr_done, tag_done, lkp_special, lkp_drop, lkp_port_mask,
			egr_discard, tag_insert, egr_queue_mode, ingress_period_sel, ingress_period_tick},
			{1'b1, 14'h0000, 2'b01, 1'b0});
		chk(hrdata, 32'h0);
		rst <= 1'b0;
		mreg = '{8'h40, 8'h00, 8'h00, 8'h10};
		rd_all();
	endtask
	// One table miss, one egress frame and one tag decision in the same cycle
	task automatic fire(input logic [1:0] c);
		logic [47:0] sa;
		logic [24:0] p8;
		logic [4:0] p0;
		logic [2:0] s;
		logic [2:0] g;
		logic sp;
		logic [11:0] ex;
		sa = $urandom_range(0, 1) ? own_mac : {$urandom, 16'h0000};
		p8 = 25'($urandom);
		p0 = 5'($urandom);
		s = 3'($urandom_range(0, 5));
		g = 3'($urandom_range(0, 5));
		sp = (c != 2'h3) && mreg[c][5];
		ex = {3'h7, sp, sp && mreg[c][4:0] == 5'h00, sp ? mreg[c][4:0] : 5'h00,
			mreg[2][6] && sa == own_mac, 1'b0};
		if (s < 5 && g < 5)
			ex[0] = mreg[3][2] ? p8[int'(g) * 5 + int'(s)] : p0[g];
		@(posedge core_clk);
		lkp_valid <= 1'b1;
		lkp_class <= c;
		egr_valid <= 1'b1;
		egr_sa <= sa;
		tag_valid <= 1'b1;
		tag_src_port <= s;
		tag_egr_port <= g;
		port_ctrl8_tag <= p8;
		port_ctrl0_tag <= p0;
		@(posedge core_clk);
		lkp_valid <= 1'b0;
		egr_valid <= 1'b0;
		tag_valid <= 1'b0;
		#1;
		chk({lkp_done, egr_done, tag_done, lkp_special, lkp_drop, lkp_port_mask,
			egr_discard, tag_insert}, ex);
		chk({egr_queue_mode, ingress_period_sel}, {mreg[3][3], mreg[3][5:4]});
	endtask
	// Choose a period, then count cycles between two ticks
	task automatic period(input logic [1:0] s, input int p);
		wr(3, {2'h0, s, 4'h0});
		// Let the restart settle so a tick of the old period is not counted
		repeat (2) @(posedge core_clk);
		while (ingress_period_tick !== 1'b1)
			@(posedge core_clk);
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (ingress_period_tick !== 1'b1);
		chk(32'(n), 32'(p));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst = 1'b1;
		{hsel, hwrite, lkp_valid, egr_valid, tag_valid} = 5'h00;
		{htrans, lkp_class, tag_src_port, tag_egr_port} = 10'h000;
		{haddr, hwdata, egr_sa} = 112'h0;
		{port_ctrl8_tag, port_ctrl0_tag} = 30'h0;
		void'($urandom(66587));
		own_mac = {$urandom, 16'h5A5A};
		reset_check(20);
		// Documented map codes with enable off and on, then random settings
		for (i = 0; i < 36; i++)
		begin
			for (j = 0; j < 5; j++)
			begin
				d = $urandom;
				wr(j, (i < 12 && j < 3) ? {1'b0, d[6], i[0], maps[i / 2]} : d[7:0]);
			end
			for (j = 0; j < 4; j++)
				fire(2'(j));
			rd_all();
		end
		for (i = 0; i < 4; i++)
			period(2'(i), i == 0 ? 16 : i == 1 ? 64 : 256);
		reset_check(2);
		close_out();
	end
	// Cut a hang short: the tests need well under 30000 cycles
	initial
	begin
		#300000;
		n_mismatch++;
		close_out();
	end
endmodule // tb_top
bind ufc_unknown_fwd_ctrl ufc_ctrl_sva ufc_ctrl_sva_i (
	.core_clk, .rst, .lkp_valid, .lkp_done, .lkp_special, .lkp_drop, .lkp_port_mask,
	.egr_valid, .egr_done, .tag_valid, .tag_done, .ingress_period_sel, .ingress_period_tick
);
`default_nettype wire

// ===== test/ufc_ctrl_sva.sv
// Port-level timing and value checks for the unknown-frame control block
`timescale 1ns/1ps
`default_nettype none
module ufc_ctrl_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic lkp_valid,
	input wire logic lkp_done,
	input wire logic lkp_special,
	input wire logic lkp_drop,
	input wire logic [4:0] lkp_port_mask,
	input wire logic egr_valid,
	input wire logic egr_done,
	input wire logic tag_valid,
	input wire logic tag_done,
	input wire logic [1:0] ingress_period_sel,
	input wire logic ingress_period_tick
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	// Every request is answered exactly one cycle later; a lookup answer is never unasked
	property p_lkp_done; lkp_valid |=> lkp_done; endproperty
	a_lkp_done: assert property (p_lkp_done) else $error("lookup not answered");
	property p_lkp_cause; lkp_done |-> $past(lkp_valid); endproperty
	a_lkp_cause: assert property (p_lkp_cause) else $error("lookup answer unasked");
	property p_egr_done; egr_valid |=> egr_done; endproperty
	a_egr_done: assert property (p_egr_done) else $error("egress check not answered");
	property p_tag_done; tag_valid |=> tag_done; endproperty
	a_tag_done: assert property (p_tag_done) else $error("tag decision not answered");
	////////////////////////////////////////////////////////////////////////////////
	// A disabled class gets no ports; a drop has an empty port set
	property p_mask_off; lkp_done && !lkp_special |-> lkp_port_mask == 5'h00 && !lkp_drop; endproperty
	a_mask_off: assert property (p_mask_off) else $error("ports given while disabled");
	property p_drop; lkp_done && lkp_drop |-> lkp_special && lkp_port_mask == 5'h00; endproperty
	a_drop: assert property (p_drop) else $error("drop with ports or disabled");
	////////////////////////////////////////////////////////////////////////////////
	// Period tick is a single pulse and restarts on a new period choice
	property p_tick_pulse; ingress_period_tick |=> !ingress_period_tick; endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("period tick too long");
	property p_tick_restart; $changed(ingress_period_sel) |-> ##2 !ingress_period_tick [*8]; endproperty
	a_tick_restart: assert property (p_tick_restart) else $error("tick soon after change");
endmodule // ufc_ctrl_sva
`default_nettype wire

// ===== verilog/ufc_period_if.sv
// Period select and tick between the control bank and its period timer
`timescale 1ns/1ps
`default_nettype none
interface ufc_period_if;
	logic [1:0] sel;
	logic tick;
	modport timer (input sel, output tick);
	modport ctrl (output sel, input tick);
endinterface
`default_nettype wire

// ===== verilog/ufc_period_timer.sv
// Ingress rate limit period timer, one tick per selected interval
`timescale 1ns/1ps
`default_nettype none
module ufc_period_timer #(
	parameter int unsigned CNT_W = 25,
	parameter int unsigned P16_CYC = ufc_pkg::UFC_P16_CYC,
	parameter int unsigned P64_CYC = ufc_pkg::UFC_P64_CYC,
	parameter int unsigned P256_CYC = ufc_pkg::UFC_P256_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	ufc_period_if.timer pif
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] last;
	logic [1:0] sel_q;

	// Terminal count of the chosen period; upper bit set means the longest
	always_comb
	begin
		if (pif.sel[1])
			last = CNT_W'(P256_CYC - 1);
		else if (pif.sel == ufc_pkg::UFC_PER_16)
			last = CNT_W'(P16_CYC - 1);
		else
			last = CNT_W'(P64_CYC - 1);
	end

	// Remember the select so that a change restarts the interval
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sel_q <= ufc_pkg::UFC_PER_64;
		else
			sel_q <= pif.sel;
	end

	// Interval counter
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cnt <= '0;
		else if (sel_q != pif.sel || cnt >= last)
			cnt <= '0;
		else
			cnt <= cnt + CNT_W'(1);
	end

	// One-cycle tick at the end of each full interval
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pif.tick <= 1'b0;
		else
			pif.tick <= (sel_q == pif.sel) && (cnt >= last);
	end

endmodule // ufc_period_timer
`default_nettype wire

// ===== verilog/ufc_pkg.sv
// Constants and types for the unknown-frame forwarding control register group
package ufc_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] UFC_IDX_MCAST = 8'h84;
	localparam logic [7:0] UFC_IDX_VLAN = 8'h85;
	localparam logic [7:0] UFC_IDX_SELF = 8'h86;
	localparam logic [7:0] UFC_IDX_RATE = 8'h87;
	localparam logic [9:0] UFC_ADDR_MCAST = 10'({UFC_IDX_MCAST, 2'b00});
	localparam logic [9:0] UFC_ADDR_RATE = 10'({UFC_IDX_RATE, 2'b00});

	// Slot of each register inside the bank
	localparam int unsigned UFC_NREG = 4;
	localparam logic [1:0] UFC_R_MCAST = 2'h0;
	localparam logic [1:0] UFC_R_VLAN = 2'h1;
	localparam logic [1:0] UFC_R_SELF = 2'h2;
	localparam logic [1:0] UFC_R_RATE = 2'h3;

	// Values after reset; reserved bits keep these forever
	localparam logic [7:0] UFC_RST [UFC_NREG] = '{8'h40, 8'h00, 8'h00, 8'h10};
	// Bits that software may change
	localparam logic [7:0] UFC_WMASK [UFC_NREG] = '{8'h3F, 8'h3F, 8'h7F, 8'h3C};

	// Field positions
	localparam int unsigned UFC_FWD_EN_BIT = 5;
	localparam int unsigned UFC_MAP_LSB = 0;
	localparam int unsigned UFC_NPORT = 5;
	localparam int unsigned UFC_SELF_FILT_BIT = 6;
	localparam int unsigned UFC_PERIOD_LSB = 4;
	localparam int unsigned UFC_QMODE_BIT = 3;
	localparam int unsigned UFC_TAGSEL_BIT = 2;

	// Ingress rate period codes and times
	localparam logic [1:0] UFC_PER_16 = 2'h0;
	localparam logic [1:0] UFC_PER_64 = 2'h1;
	localparam int unsigned UFC_PER16_MS = 16;
	localparam int unsigned UFC_PER64_MS = 64;
	localparam int unsigned UFC_PER256_MS = 256;
	localparam int unsigned UFC_CLK_KHZ = 100000;
	localparam int unsigned UFC_P16_CYC = UFC_PER16_MS * UFC_CLK_KHZ;
	localparam int unsigned UFC_P64_CYC = UFC_PER64_MS * UFC_CLK_KHZ;
	localparam int unsigned UFC_P256_CYC = UFC_PER256_MS * UFC_CLK_KHZ;

	// Kind of frame that missed the forwarding table
	typedef enum logic [1:0] {
		UFC_CLS_MCAST = 2'b00,
		UFC_CLS_VLAN = 2'b01,
		UFC_CLS_IPMC = 2'b10,
		UFC_CLS_NONE = 2'b11
	} ufc_class_t;

	// Data phase of the register bus
	typedef enum logic [1:0] {
		UFC_BUS_IDLE = 2'b00,
		UFC_BUS_WR = 2'b01,
		UFC_BUS_RDW = 2'b10,
		UFC_BUS_RDD = 2'b11
	} ufc_bus_st_t;

endpackage

// ===== verilog/ufc_unknown_fwd_ctrl.sv
// Unknown-frame forwarding, self-address filter, rate period and tag control
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Multicast miss (not IP) gets special forwarding only while its enable is one.
// - Multicast map 00111, 01111, 11111 steer to ports 1-3, 1-4, all.
// - VLAN-ID miss gets special forwarding only while its enable is one.
// - VLAN map 00000 drops; 00001 up to 11111 widen the port set.
// - Self-address filter off keeps own-address frames; on filters them; resets off.
// - Filtering happens at egress, comparing against the separately held own MAC.
// - IP multicast miss gets special forwarding only while its enable is one.
// - IP multicast map 00000 drops; 00001 up to 11111 widen the port set.
// - Period field 00 is 16 ms, 01 is 64 ms, 1x is 256 ms; resets 01.
// - Egress limit mode bit zero means per port, one means per queue.
// - Tag select one: each egress port decides per source port by control 8.
// - Tag select zero: insertion set only by each port's control 0 bit 2.
////////////////////////////////////////////////////////////////////////////////
module ufc_unknown_fwd_ctrl #(
	parameter int unsigned CNT_W = 25,
	parameter int unsigned P16_CYC = ufc_pkg::UFC_P16_CYC,
	parameter int unsigned P64_CYC = ufc_pkg::UFC_P64_CYC,
	parameter int unsigned P256_CYC = ufc_pkg::UFC_P256_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Forwarding table miss
	input wire logic lkp_valid,
	input wire logic [1:0] lkp_class,
	output logic lkp_done,
	output logic lkp_special,
	output logic lkp_drop,
	output logic [4:0] lkp_port_mask,
	// Egress self-address check
	input wire logic egr_valid,
	input wire logic [47:0] egr_sa,
	input wire logic [47:0] own_mac,
	output logic egr_done,
	output logic egr_discard,
	// Egress tag insertion decision
	input wire logic tag_valid,
	input wire logic [2:0] tag_src_port,
	input wire logic [2:0] tag_egr_port,
	input wire logic [24:0] port_ctrl8_tag,
	input wire logic [4:0] port_ctrl0_tag,
	output logic tag_done,
	output logic tag_insert,
	// Rate limit configuration
	output logic egr_queue_mode,
	output logic [1:0] ingress_period_sel,
	output logic ingress_period_tick
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge written data into the software-writable bits only
	function automatic logic [7:0] merge_wr(input logic [7:0] old,
		input logic [7:0] wdata, input logic [7:0] wmask);
		merge_wr = (old & ~wmask) | (wdata & wmask);
	endfunction

	// Bank slot of a byte address; hit low when nothing is mapped there
	function automatic logic [2:0] decode_addr(input logic [31:0] addr);
		logic [9:0] a;
		a = addr[9:0];
		if (a[1:0] != 2'b00 || a < ufc_pkg::UFC_ADDR_MCAST || a > ufc_pkg::UFC_ADDR_RATE)
			decode_addr = 3'h0;
		else
			decode_addr = {1'b1, a[3:2]};
	endfunction

	// Bank slot that governs a class of table miss
	function automatic logic [1:0] class_slot(input ufc_pkg::ufc_class_t cls);
		case (cls)
			ufc_pkg::UFC_CLS_MCAST: class_slot = ufc_pkg::UFC_R_MCAST;
			ufc_pkg::UFC_CLS_VLAN: class_slot = ufc_pkg::UFC_R_VLAN;
			default: class_slot = ufc_pkg::UFC_R_SELF;
		endcase
	endfunction

	// Port map field of a forwarding control register
	// Used for both the port set and the drop test, so they never disagree
	function automatic logic [4:0] port_map(input logic [7:0] ctrl);
		port_map = ctrl[ufc_pkg::UFC_MAP_LSB +: ufc_pkg::UFC_NPORT];
	endfunction

	// Ingress period select field of the rate control register
	function automatic logic [1:0] period_field(input logic [7:0] ctrl);
		period_field = ctrl[ufc_pkg::UFC_PERIOD_LSB +: 2];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bank

	logic [7:0] bank [ufc_pkg::UFC_NREG];
	logic [7:0] unknown_mcast_forward_ctrl;
	logic [7:0] unknown_vlan_forward_ctrl;
	logic [7:0] self_filter_ip_mcast_ctrl;
	logic [7:0] rate_limit_tag_insert_ctrl;

	ufc_pkg::ufc_bus_st_t bus_st;
	ufc_pkg::ufc_bus_st_t next_bus_st;
	logic [2:0] dp_slot;
	logic [2:0] ap_slot;
	logic ap_take;

	assign unknown_mcast_forward_ctrl = bank[ufc_pkg::UFC_R_MCAST];
	assign unknown_vlan_forward_ctrl = bank[ufc_pkg::UFC_R_VLAN];
	assign self_filter_ip_mcast_ctrl = bank[ufc_pkg::UFC_R_SELF];
	assign rate_limit_tag_insert_ctrl = bank[ufc_pkg::UFC_R_RATE];

	// Address phase accepted when selected, active and the bus is ready
	assign ap_take = hsel && htrans[1] && hready;
	assign ap_slot = decode_addr(haddr);

	// One storage byte per register; reserved bits hold their reset pattern
	genvar gi;
	generate
		for (gi = 0; gi < ufc_pkg::UFC_NREG; gi++)
		begin : g_bank
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					bank[gi] <= ufc_pkg::UFC_RST[gi];
				else if (bus_st == ufc_pkg::UFC_BUS_WR && dp_slot == {1'b1, 2'(gi)})
					bank[gi] <= merge_wr(bank[gi], hwdata[7:0], ufc_pkg::UFC_WMASK[gi]);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: writes without wait, reads with one wait state

	// Writes land at the end of their data phase; the read wait cycle
	// lets a read that follows a write see the new value
	// Next data-phase state; a read always passes one wait cycle
	always_comb
	begin
		next_bus_st = ufc_pkg::UFC_BUS_IDLE;
		unique case (bus_st)
			ufc_pkg::UFC_BUS_RDW:
				next_bus_st = ufc_pkg::UFC_BUS_RDD;
			ufc_pkg::UFC_BUS_IDLE, ufc_pkg::UFC_BUS_WR, ufc_pkg::UFC_BUS_RDD:
			begin
				if (ap_take && hwrite)
					next_bus_st = ufc_pkg::UFC_BUS_WR;
				else if (ap_take)
					next_bus_st = ufc_pkg::UFC_BUS_RDW;
			end
		endcase
	end

	// Data-phase state
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bus_st <= ufc_pkg::UFC_BUS_IDLE;
		else
			bus_st <= next_bus_st;
	end

	// Slot of the transfer in data phase, held through a read's wait cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			dp_slot <= 3'h0;
		else if (bus_st != ufc_pkg::UFC_BUS_RDW)
			dp_slot <= ap_take ? ap_slot : 3'h0;
	end

	// Ready drops only for the wait cycle of a read
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hreadyout <= 1'b1;
		else
			hreadyout <= (next_bus_st != ufc_pkg::UFC_BUS_RDW);
	end

	// Read data loaded during the wait cycle, after any earlier write landed
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (bus_st == ufc_pkg::UFC_BUS_RDW)
			hrdata <= dp_slot[2] ? {24'h00_0000, bank[dp_slot[1:0]]} : 32'h0000_0000;
	end

	// Every transfer, mapped or not, answers OKAY
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Unknown multicast, VLAN ID and IP multicast forwarding

	logic [7:0] cls_reg;
	logic cls_en;
	logic cls_none;

	// Pick the register that governs this miss
	always_comb
	begin
		cls_none = (ufc_pkg::ufc_class_t'(lkp_class) == ufc_pkg::UFC_CLS_NONE);
		cls_reg = bank[class_slot(ufc_pkg::ufc_class_t'(lkp_class))];
		cls_en = cls_reg[ufc_pkg::UFC_FWD_EN_BIT] && !cls_none;
	end

	// Answer strobe, exactly one cycle after each request
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lkp_done <= 1'b0;
		else
			lkp_done <= lkp_valid;
	end

	// Special forwarding flag; a disabled class falls back to normal flow
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lkp_special <= 1'b0;
		else if (lkp_valid)
			lkp_special <= cls_en;
	end

	// Ports of the miss; map bit n-1 names port n, none while disabled
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lkp_port_mask <= 5'h00;
		else if (lkp_valid)
			lkp_port_mask <= cls_en ? port_map(cls_reg) : 5'h00;
	end

	// Drop when the class is enabled with an empty map
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lkp_drop <= 1'b0;
		else if (lkp_valid)
			lkp_drop <= cls_en && (port_map(cls_reg) == 5'h00);
	end

	////////////////////////////////////////////////////////////////////////////
	// Egress self-address filter

	// Answer strobe for the egress check
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			egr_done <= 1'b0;
		else
			egr_done <= egr_valid;
	end

	// Discard frames whose source matches the own MAC while the filter is on
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			egr_discard <= 1'b0;
		else if (egr_valid)
			egr_discard <= self_filter_ip_mcast_ctrl[ufc_pkg::UFC_SELF_FILT_BIT]
				&& (egr_sa == own_mac);
	end

	////////////////////////////////////////////////////////////////////////////
	// Default VLAN tag insertion

	logic tag_ports_ok;
	logic [4:0] tag_row;

	// Control 8 bits of the egress port, one bit per source port
	// Row offset is worked out five bits wide; three bits would wrap from port 2 on
	always_comb
	begin
		tag_ports_ok = (tag_src_port < 3'(ufc_pkg::UFC_NPORT))
			&& (tag_egr_port < 3'(ufc_pkg::UFC_NPORT));
		tag_row = 5'h00;
		if (tag_ports_ok)
			tag_row = port_ctrl8_tag[5'(tag_egr_port) * 5'd5 +: 5];
	end

	// Answer strobe for the tag decision
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tag_done <= 1'b0;
		else
			tag_done <= tag_valid;
	end

	// Per-source choice when selected, else the egress port's control 0 bit
	// Out-of-range port numbers never insert a tag
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tag_insert <= 1'b0;
		else if (tag_valid && !tag_ports_ok)
			tag_insert <= 1'b0;
		else if (tag_valid && rate_limit_tag_insert_ctrl[ufc_pkg::UFC_TAGSEL_BIT])
			tag_insert <= tag_row[tag_src_port];
		else if (tag_valid)
			tag_insert <= port_ctrl0_tag[tag_egr_port];
	end

	////////////////////////////////////////////////////////////////////////////
	// Rate limit configuration and ingress period

	ufc_period_if pif ();

	assign pif.sel = period_field(rate_limit_tag_insert_ctrl);
	assign ingress_period_sel = period_field(rate_limit_tag_insert_ctrl);
	assign egr_queue_mode = rate_limit_tag_insert_ctrl[ufc_pkg::UFC_QMODE_BIT];
	assign ingress_period_tick = pif.tick;

	// Interval timer for ingress rate measurement
	ufc_period_timer #(
		.CNT_W(CNT_W),
		.P16_CYC(P16_CYC),
		.P64_CYC(P64_CYC),
		.P256_CYC(P256_CYC)
	) u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.pif(pif)
	);

endmodule // ufc_unknown_fwd_ctrl
`default_nettype wire
